// ### rtl/dtcu_pkg.sv
package dtcu_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] DTCU_IDX_CONTROL = 8'h88;   // timer_control
    localparam logic [7:0] DTCU_IDX_MODE    = 8'h89;   // timer_mode_select
    localparam logic [7:0] DTCU_IDX_U0_LO   = 8'h8A;   // unit0_low_byte
    localparam logic [7:0] DTCU_IDX_U1_LO   = 8'h8B;   // unit1_low_byte
    localparam logic [7:0] DTCU_IDX_U0_HI   = 8'h8C;   // unit0_high_byte
    localparam logic [7:0] DTCU_IDX_U1_HI   = 8'h8D;   // unit1_high_byte
    localparam int         DTCU_ADR_W       = 10;      // byte address width used

    // ************************************************************
    // timer_control field positions
    // ************************************************************
    localparam int DTCU_RUN0_BIT = 4;                  // unit0_run
    localparam int DTCU_OVF0_BIT = 5;                  // unit0_overflow_flag
    localparam int DTCU_RUN1_BIT = 6;                  // unit1_run
    localparam int DTCU_OVF1_BIT = 7;                  // unit1_overflow_flag
    localparam int DTCU_MODE_U1_LSB = 4;               // unit 1 nibble in mode byte

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] DTCU_RESET_BYTE = 8'h00;    // all registers
    localparam logic [3:0] DTCU_PHASE_RESET = 4'h0;    // S1P1

    // ************************************************************
    // machine cycle timing, phase n = 2*(state-1) + (phase-1)
    // ************************************************************
    localparam int         DTCU_OSC_PER_MC  = 12;      // oscillator periods per cycle
    localparam logic [3:0] DTCU_PH_LAST     = 4'(DTCU_OSC_PER_MC - 1);
    localparam logic [3:0] DTCU_PH_SAMPLE   = 4'h9;    // S5P2
    localparam logic [3:0] DTCU_PH_UPDATE   = 4'h4;    // S3P1

    // ************************************************************
    // operating modes
    // ************************************************************
    localparam logic [1:0] DTCU_MODE_13BIT  = 2'h0;
    localparam logic [1:0] DTCU_MODE_16BIT  = 2'h1;
    localparam logic [1:0] DTCU_MODE_RELOAD = 2'h2;
    localparam logic [1:0] DTCU_MODE_SPLIT  = 2'h3;

    // per-unit nibble of timer_mode_select
    typedef struct packed {
        logic gate;                                    // gate on interrupt pin
        logic count_sel;                               // 1 counter, 0 timer
        logic mode_select_high;
        logic mode_select_low;
    } dtcu_umode_t;

    // external pin group
    typedef struct packed {
        logic ext_gate_in_one;
        logic ext_gate_in_zero;
        logic count_in_one;
        logic count_in_zero;
    } dtcu_pins_t;

    // bus slave states
    typedef enum logic [1:0] {
        DTCU_WB_IDLE = 2'b01,
        DTCU_WB_ACK  = 2'b10
    } dtcu_wb_state_t;

endpackage : dtcu_pkg

// ### rtl/dtcu_edge_sampler.sv
`timescale 1ns/1ps
module dtcu_edge_sampler (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // timing strobes
    input  wire logic sample_i,
    input  wire logic update_i,
    // pin and result
    input  wire logic pin_i,
    output logic      edge_o
);
    import dtcu_pkg::*;

    // ************************************************************
    // sample once per machine cycle, keep edge until update
    // ************************************************************
    logic sample_q;                                    // previous sample
    logic pend_q;                                      // edge awaiting count
    logic pend_d;

    // high then low between two samples marks an edge
    assign pend_d = (sample_i & sample_q & ~pin_i) | (pend_q & ~update_i);

    // sample register and pending edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_q <= 1'b0;
            pend_q   <= 1'b0;
        end else begin
            if (sample_i) begin
                sample_q <= pin_i;
            end
            pend_q <= pend_d;
        end
    end

    assign edge_o = pend_q;

endmodule : dtcu_edge_sampler

// ### rtl/dtcu_top.sv
// Summary of operation
// - timer mode counts once per twelve clocks
// - counter mode counts falling count input edges
// - sample at S5P2, high then low edge
// - count appears at S3P1 next cycle
// - mode 0 low byte prescales by 32
// - mode 1 cascades bytes to 16 bits
// - mode 2 low counts, high reloads
// - mode 3 unit0 splits into two bytes
// - unit1 in mode 3 holds its count
// - gate input level may gate counting
// - run bits 4 and 6 start units
// - overflow flags bits 5,7; vector clears
// - lower control nibble does not affect timing
// - reset zeroes control and counter bytes
// - each unit is two byte registers
// - count inputs come from port pins
// - mode nibble: gate, select, two mode bits
// - mode 0 uses 13 bits
// - mode 2 overflow reloads, high unchanged
// - split high byte uses unit1 run/flag
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module dtcu_top (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [dtcu_pkg::DTCU_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // external pins
    input  wire dtcu_pkg::dtcu_pins_t          pins_i,
    // interrupt vector acknowledge
    input  wire logic                          vec_ack0_i,
    input  wire logic                          vec_ack1_i,
    // flag outputs
    output logic                               ovf0_o,
    output logic                               ovf1_o,
    output logic      [3:0]                    ext_irq_ctl_o
);
    import dtcu_pkg::*;

    // ************************************************************
    // step function for one unit in its mode
    // ************************************************************
    // returns {overflow, high, low}; split mode leaves high alone
    function automatic logic [16:0] dtcu_step(
        input logic [1:0] mode,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [12:0] c13;
        logic [15:0] c16;
        logic [16:0] res;
        c13 = {hi, lo[4:0]};
        c16 = {hi, lo};
        res = {1'b0, hi, lo};
        case (mode)
            DTCU_MODE_13BIT: begin
                // upper three low bits kept, not counted
                c13 = c13 + 13'h0001;
                res = {(c13 == 13'h0000), c13[12:5], lo[7:5], c13[4:0]};
            end
            DTCU_MODE_16BIT: begin
                c16 = c16 + 16'h0001;
                res = {(c16 == 16'h0000), c16};
            end
            DTCU_MODE_RELOAD: begin
                // low rolls over into the reload byte
                if (lo == 8'hFF) begin
                    res = {1'b1, hi, hi};
                end else begin
                    res = {1'b0, hi, 8'(lo + 8'h01)};
                end
            end
            DTCU_MODE_SPLIT: begin
                // low byte only, high handled apart
                res = {(lo == 8'hFF), hi, 8'(lo + 8'h01)};
            end
            default: begin
                res = {1'b0, hi, lo};
            end
        endcase
        return res;
    endfunction : dtcu_step

    // ************************************************************
    // machine cycle phase divider
    // ************************************************************
    logic [3:0]  phase_q;                              // 0 = S1P1 .. 11 = S6P2
    logic [3:0]  phase_d;
    logic        sample_tick;                          // S5P2 strobe
    logic        mc_tick;                              // S3P1 strobe

    // twelve clocks make one machine cycle
    assign phase_d     = (phase_q == DTCU_PH_LAST) ? DTCU_PHASE_RESET
                                                   : 4'(phase_q + 4'h1);
    assign sample_tick = (phase_q == DTCU_PH_SAMPLE);
    assign mc_tick     = (phase_q == DTCU_PH_UPDATE);

    // phase counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= DTCU_PHASE_RESET;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0]  ctrl_q;                               // timer_control
    logic [7:0]  ctrl_d;
    logic [7:0]  mode_q;                               // timer_mode_select
    logic [7:0]  mode_d;
    logic [7:0]  lo0_q;                                // unit0_low_byte
    logic [7:0]  lo0_d;
    logic [7:0]  hi0_q;                                // unit0_high_byte
    logic [7:0]  hi0_d;
    logic [7:0]  lo1_q;                                // unit1_low_byte
    logic [7:0]  lo1_d;
    logic [7:0]  hi1_q;                                // unit1_high_byte
    logic [7:0]  hi1_d;
    dtcu_umode_t u0;                                   // unit 0 mode nibble
    dtcu_umode_t u1;                                   // unit 1 mode nibble
    logic [1:0]  m0;                                   // unit 0 mode number
    logic [1:0]  m1;                                   // unit 1 mode number

    // nibble is gate, select, mode
    // mode nibbles decoded
    assign u0 = dtcu_umode_t'(mode_q[DTCU_MODE_U1_LSB-1:0]);
    assign u1 = dtcu_umode_t'(mode_q[7:DTCU_MODE_U1_LSB]);
    assign m0 = {u0.mode_select_high, u0.mode_select_low};
    assign m1 = {u1.mode_select_high, u1.mode_select_low};

    // ************************************************************
    // wishbone slave: decode and handshake
    // ************************************************************
    dtcu_wb_state_t wb_state_q;                        // idle or acking
    dtcu_wb_state_t wb_state_d;
    logic [7:0]  rdat_q;                               // latched read byte
    logic [7:0]  rdat_d;
    logic [7:0]  idx;                                  // word index
    logic [7:0]  wbyte;                                // write byte lane 0
    logic        acc;                                  // request taken
    logic        wr;                                   // write taken
    logic        hit_ctl;
    logic        hit_mode;
    logic        hit_lo0;
    logic        hit_hi0;
    logic        hit_lo1;
    logic        hit_hi1;

    assign idx      = wb_adr_i[DTCU_ADR_W-1:2];
    assign wbyte    = wb_dat_i[7:0];
    assign acc      = wb_cyc_i & wb_stb_i & (wb_state_q == DTCU_WB_IDLE);
    assign wr       = acc & wb_we_i & wb_sel_i[0];
    assign hit_ctl  = (idx == DTCU_IDX_CONTROL);
    assign hit_mode = (idx == DTCU_IDX_MODE);
    assign hit_lo0  = (idx == DTCU_IDX_U0_LO);
    assign hit_hi0  = (idx == DTCU_IDX_U0_HI);
    assign hit_lo1  = (idx == DTCU_IDX_U1_LO);
    assign hit_hi1  = (idx == DTCU_IDX_U1_HI);

    // read mux, unmapped reads zero
    assign rdat_d = ~acc     ? rdat_q :
                    hit_ctl  ? ctrl_q :
                    hit_mode ? mode_q :
                    hit_lo0  ? lo0_q  :
                    hit_hi0  ? hi0_q  :
                    hit_lo1  ? lo1_q  :
                    hit_hi1  ? hi1_q  : DTCU_RESET_BYTE;

    // one ack per request, then one idle cycle
    always_comb begin
        case (wb_state_q)
            DTCU_WB_IDLE: begin
                wb_state_d = acc ? DTCU_WB_ACK : DTCU_WB_IDLE;
            end
            DTCU_WB_ACK: begin
                wb_state_d = DTCU_WB_IDLE;
            end
            default: begin
                wb_state_d = DTCU_WB_IDLE;
            end
        endcase
    end

    // bus state and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_state_q <= DTCU_WB_IDLE;
            rdat_q     <= DTCU_RESET_BYTE;
        end else begin
            wb_state_q <= wb_state_d;
            rdat_q     <= rdat_d;
        end
    end

    // ack and data come from flops
    assign wb_ack_o = (wb_state_q == DTCU_WB_ACK);
    assign wb_dat_o = {24'h000000, rdat_q};

    // ************************************************************
    // count input edge detection
    // ************************************************************
    logic        edge0;                                // pending edge unit 0
    logic        edge1;                                // pending edge unit 1

    // both pins share the phase strobes
    // unit 0 count input pin
    dtcu_edge_sampler u_edge0 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sample_i (sample_tick),
        .update_i (mc_tick),
        .pin_i    (pins_i.count_in_zero),
        .edge_o   (edge0)
    );

    // unit 1 count input pin
    dtcu_edge_sampler u_edge1 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sample_i (sample_tick),
        .update_i (mc_tick),
        .pin_i    (pins_i.count_in_one),
        .edge_o   (edge1)
    );

    // ************************************************************
    // count enables
    // ************************************************************
    logic        run0;
    logic        run1;
    logic        gate_ok0;                             // gate open unit 0
    logic        gate_ok1;                             // gate open unit 1
    logic        src0;                                 // count source unit 0
    logic        src1;                                 // count source unit 1
    logic        split0;                               // unit 0 in mode 3
    logic        en0;                                  // unit 0 step
    logic        en1;                                  // unit 1 step
    logic        en0h;                                 // split high byte step

    // gate pin level used as it arrives
    // lower control nibble never enters these terms
    assign run0     = ctrl_q[DTCU_RUN0_BIT];
    assign run1     = ctrl_q[DTCU_RUN1_BIT];
    assign gate_ok0 = ~u0.gate | pins_i.ext_gate_in_zero;
    assign gate_ok1 = ~u1.gate | pins_i.ext_gate_in_one;
    assign src0     = u0.count_sel ? edge0 : 1'b1;
    assign src1     = u1.count_sel ? edge1 : 1'b1;
    assign split0   = (m0 == DTCU_MODE_SPLIT);
    assign en0      = mc_tick & run0 & gate_ok0 & src0;
    // unit 1 frozen in its own mode 3
    assign en1      = mc_tick & run1 & gate_ok1 & src1
                      & (m1 != DTCU_MODE_SPLIT);
    // split high byte counts machine cycles on unit 1 run bit
    assign en0h     = mc_tick & run1 & split0;

    // ************************************************************
    // next counter values and overflows
    // ************************************************************
    logic [16:0] step0;                                // unit 0 result
    logic [16:0] step1;                                // unit 1 result
    logic        ovf0;                                 // unit 0 overflow
    logic        ovf1;                                 // flag 1 overflow

    assign step0 = dtcu_step(m0, lo0_q, hi0_q);
    assign step1 = dtcu_step(m1, lo1_q, hi1_q);
    assign ovf0  = en0 & step0[16];
    // split mode hands flag 1 to unit 0 high byte
    assign ovf1  = split0 ? (en0h & (hi0_q == 8'hFF))
                          : (en1 & step1[16]);

    // software write wins over a count step on the same byte
    assign lo0_d = (wr & hit_lo0) ? wbyte :
                   en0            ? step0[7:0] : lo0_q;
    assign hi0_d = (wr & hit_hi0) ? wbyte :
                   en0h           ? 8'(hi0_q + 8'h01) :
                   en0            ? step0[15:8] : hi0_q;
    assign lo1_d = (wr & hit_lo1) ? wbyte :
                   en1            ? step1[7:0] : lo1_q;
    assign hi1_d = (wr & hit_hi1) ? wbyte :
                   en1            ? step1[15:8] : hi1_q;
    assign mode_d = (wr & hit_mode) ? wbyte : mode_q;

    // control byte: write, vector clear, then hardware set wins
    always_comb begin
        ctrl_d = (wr & hit_ctl) ? wbyte : ctrl_q;
        if (vec_ack0_i) begin
            ctrl_d[DTCU_OVF0_BIT] = 1'b0;
        end
        if (vec_ack1_i) begin
            ctrl_d[DTCU_OVF1_BIT] = 1'b0;
        end
        if (ovf0) begin
            ctrl_d[DTCU_OVF0_BIT] = 1'b1;
        end
        if (ovf1) begin
            ctrl_d[DTCU_OVF1_BIT] = 1'b1;
        end
    end

    // ************************************************************
    // register update
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= DTCU_RESET_BYTE;
            mode_q <= DTCU_RESET_BYTE;
            lo0_q  <= DTCU_RESET_BYTE;
            hi0_q  <= DTCU_RESET_BYTE;
            lo1_q  <= DTCU_RESET_BYTE;
            hi1_q  <= DTCU_RESET_BYTE;
        end else begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            lo0_q  <= lo0_d;
            hi0_q  <= hi0_d;
            lo1_q  <= lo1_d;
            hi1_q  <= hi1_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // flags read back from control
    assign ovf0_o        = ctrl_q[DTCU_OVF0_BIT];
    assign ovf1_o        = ctrl_q[DTCU_OVF1_BIT];
    assign ext_irq_ctl_o = ctrl_q[3:0];

endmodule : dtcu_top

// ### sim/dtcu_pin_model.sv
`timescale 1ns/1ps
// ****************************************
// count and gate pin source
// ****************************************
module dtcu_pin_model (
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // bench controls
    input  wire logic            run_i,
    input  wire logic [1:0]      gate_i,
    // pins toward the block
    output dtcu_pkg::dtcu_pins_t pins_o
);
    import dtcu_pkg::*;
    localparam logic [3:0] HOLD = 4'hC;  // 13 clocks per level, above one machine cycle
    logic [3:0] hold_q;                   // clocks spent at this level
    logic       lvl_q = 1'b1;             // count pin level
    // toggle after a full hold, stand still when stopped
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            hold_q <= 4'h0;
        end else if (hold_q == HOLD) begin
            hold_q <= 4'h0;
            lvl_q  <= !lvl_q;
        end else begin
            hold_q <= hold_q + 4'h1;
        end
    end
    // both count inputs move, in opposite phase
    assign pins_o = {gate_i, !lvl_q, lvl_q};
endmodule : dtcu_pin_model

// ### sim/dtcu_top_sva.sv
`timescale 1ns/1ps
// ****************************************
// bus and flag checks at the block ports
// ****************************************
module dtcu_top_sva (
    // clock and reset
    input wire logic                             clk_i,
    input wire logic                             rst_i,
    // register bus
    input wire logic                             wb_cyc_i,
    input wire logic                             wb_stb_i,
    input wire logic                             wb_we_i,
    input wire logic [dtcu_pkg::DTCU_ADR_W-1:0]  wb_adr_i,
    input wire logic [3:0]                       wb_sel_i,
    input wire logic [31:0]                      wb_dat_i,
    input wire logic [31:0]                      wb_dat_o,
    input wire logic                             wb_ack_o,
    // pins and flags
    input wire dtcu_pkg::dtcu_pins_t             pins_i,
    input wire logic                             vec_ack0_i,
    input wire logic                             vec_ack1_i,
    input wire logic                             ovf0_o,
    input wire logic                             ovf1_o,
    input wire logic [3:0]                       ext_irq_ctl_o
);
    import dtcu_pkg::*;
    logic [3:0] ph_q;                                      // machine cycle phase
    wire        take   = wb_cyc_i && wb_stb_i && !wb_ack_o; // request taken
    wire [7:0]  idx    = wb_adr_i[9:2];                    // register index
    wire        ctl_wr = take && wb_we_i && wb_sel_i[0] && idx == DTCU_IDX_CONTROL;
    wire        bad_rd = take && !wb_we_i && (idx < DTCU_IDX_CONTROL || idx > DTCU_IDX_U1_HI);
    // phase tracker, counters step at the edge ending phase 4
    always_ff @(posedge clk_i) begin
        if (rst_i) ph_q <= 4'h0;
        else ph_q <= (ph_q == DTCU_PH_LAST) ? 4'h0 : ph_q + 4'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
    property p_bad_rd; bad_rd |=> wb_ack_o && wb_dat_o == 32'h0; endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
    property p_ovf_rise; $rose(ovf0_o) || $rose(ovf1_o) |-> $past(ph_q) == 4'h4 || $past(ctl_wr);
    endproperty
    a_ovf_rise: assert property (p_ovf_rise) else $error("flag set off step");
    property p_ovf_fall; $fell(ovf0_o) |-> $past(vec_ack0_i) || $past(ctl_wr); endproperty
    a_ovf_fall: assert property (p_ovf_fall) else $error("flag lost");
    property p_vec_clr; vec_ack0_i && ph_q != 4'h4 && !ctl_wr |=> !ovf0_o; endproperty
    a_vec_clr: assert property (p_vec_clr) else $error("vector clear missed");
    property p_irq_wr; ctl_wr |=> ext_irq_ctl_o == $past(wb_dat_i[3:0]); endproperty
    a_irq_wr: assert property (p_irq_wr) else $error("control nibble not stored");
    property p_irq_keep; !ctl_wr |=> $stable(ext_irq_ctl_o); endproperty
    a_irq_keep: assert property (p_irq_keep) else $error("control nibble moved");
    c_ovf0: cover property ($rose(ovf0_o));
    c_ovf1: cover property ($rose(ovf1_o));
    c_vec: cover property (vec_ack0_i && ovf0_o);
endmodule : dtcu_top_sva
bind dtcu_top dtcu_top_sva u_dtcu_top_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins_i),
    .vec_ack0_i(vec_ack0_i), .vec_ack1_i(vec_ack1_i), .ovf0_o(ovf0_o), .ovf1_o(ovf1_o),
    .ext_irq_ctl_o(ext_irq_ctl_o));

// ### sim/tb_dtcu_top.sv
`timescale 1ns/1ps
module tb_dtcu_top;
    import dtcu_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, v0 = 1'b0, v1 = 1'b0;
    logic ovf0, ovf1, cnt_run = 1'b1;
    logic [1:0]  gate = 2'b11;                     // gate pin levels
    logic [3:0]  irq;                              // control nibble copy
    logic [9:0]  adr = 10'h000;                    // bus byte address
    logic [31:0] dat = 32'h0, rdat;                // bus data
    dtcu_pins_t  pins;                             // pin group
    logic [7:0]  r, d, m, lo, hi, t1, k;           // scratch bytes
    logic [7:0]  idx_tab [6] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D};
    logic [7:0]  mode_tab [6] = '{8'h00, 8'h01, 8'h02, 8'h33, 8'h05, 8'h09};
    int num_errors = 0, n_tests = 0, cycles = 0, seed;
    // ****************************************
    // clock, parts, timeout
    // ****************************************
    always #25 clk_i = ~clk_i;
    dtcu_pin_model u_dtcu_pin_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(cnt_run),
        .gate_i(gate), .pins_o(pins));
    dtcu_top u_dtcu_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pins_i(pins), .vec_ack0_i(v0), .vec_ack1_i(v1), .ovf0_o(ovf0),
        .ovf1_o(ovf1), .ext_irq_ctl_o(irq));
    // hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // compare one byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one classic bus cycle, answer taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] v,
                      output logic [7:0] q);
        cyc <= 1'b1;
        we  <= w;
        adr <= {i, 2'b00};
        dat <= {24'h0, v};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // wait a bounded time for a flag
    task automatic wait_ovf(input logic u);
        int n;
        n = 0;
        while ((u ? ovf1 : ovf0) !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk({7'h0, u ? ovf1 : ovf0}, 8'h01);
    endtask : wait_ovf
    // low byte after one overflow step
    function automatic logic [7:0] exp_lo(input logic [7:0] mm, input logic [7:0] l,
                                          input logic [7:0] h);
        case (mm[1:0])
            2'h0:    return {l[7:5], 5'h00};
            2'h2:    return h;
            default: return 8'h00;
        endcase
    endfunction : exp_lo
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 61;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (idx_tab[i]) begin
            wb(1'b0, idx_tab[i], 8'h00, r);
            chk(r, 8'h00);
        end
        wb(1'b0, 8'h90, 8'h00, r);
        chk(r, 8'h00);
        // counter bytes hold what was written while stopped
        for (int i = 2; i < 6; i++) begin
            d = 8'($random(seed));
            wb(1'b1, idx_tab[i], d, r);
            wb(1'b0, idx_tab[i], 8'h00, r);
            chk(r, d);
        end
        // one overflow per mode, gated and counter cases held first
        foreach (mode_tab[c]) begin
            m  = mode_tab[c];
            d  = 8'($random(seed));
            t1 = 8'($random(seed));
            lo = (m == 8'h00) ? {d[7:5], 5'h1F} : 8'hFF;
            hi = (m == 8'h02) ? d : 8'hFF;
            gate    <= {1'b1, !m[3]};
            cnt_run <= !m[2];
            wb(1'b1, 8'h89, m, r);
            wb(1'b1, 8'h8A, lo, r);
            wb(1'b1, 8'h8C, hi, r);
            wb(1'b1, 8'h8B, t1, r);
            repeat (12) @(posedge clk_i);
            k = {4'h0, d[3:0]} | ((m == 8'h33) ? 8'h50 : 8'h10);
            wb(1'b1, 8'h88, k, r);
            chk({4'h0, irq}, {4'h0, k[3:0]});
            if (m[3] || m[2]) begin
                repeat (40) @(posedge clk_i);
                chk({7'h0, ovf0}, 8'h00);
                gate    <= 2'b11;
                cnt_run <= 1'b1;
            end
            wait_ovf(1'b0);
            if (m == 8'h33) wait_ovf(1'b1);
            chk({7'h0, ovf1}, {7'h0, m == 8'h33});
            wb(1'b1, 8'h88, 8'hA0, r);
            wb(1'b0, 8'h8A, 8'h00, r);
            chk(r, exp_lo(m, lo, hi));
            wb(1'b0, 8'h8C, 8'h00, r);
            chk(r, (m == 8'h02) ? hi : 8'h00);
            wb(1'b0, 8'h8B, 8'h00, r);
            chk(r, t1);
            v0 <= 1'b1;
            v1 <= 1'b1;
            @(posedge clk_i);
            v0 <= 1'b0;
            v1 <= 1'b0;
            @(posedge clk_i);
            chk({6'h0, ovf1, ovf0}, 8'h00);
        end
        give_verdict();
    end
endmodule : tb_dtcu_top
